// file: hw/pmew_pkg.sv
// Constants and carrier types of the wake event and sleep watchdog block
package pmew_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WDT_CTRL = 8'hED;
  localparam logic [7:0] IDX_WDT_TIME = 8'hEE;
  localparam logic [7:0] IDX_EN_ONE = 8'hF0;
  localparam logic [7:0] IDX_ST_ONE = 8'hF1;
  localparam logic [7:0] IDX_EN_TWO = 8'hF2;
  localparam logic [7:0] IDX_ST_TWO = 8'hF3;
  localparam logic [7:0] IDX_WAKE_EN = 8'hE8;
  localparam logic [7:0] IDX_IRQ_ST = 8'hFA;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hFB;

  // Watchdog control fields; TIMER_WAKE_BIT sits in the wakeup enable register
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int FOLLOW_BIT = 5;
  localparam int EXPIRED_BIT = 4;
  localparam int UNIT_BIT = 1;
  localparam int ENABLE_BIT = 0;
  localparam int TIMER_WAKE_BIT = 2;

  // Writable bits of each register
  localparam logic [7:0] CTRL_RW_MASK = 8'hE3;
  localparam logic [7:0] EN_ONE_MASK = 8'hF2;
  localparam logic [7:0] ST_ONE_MASK = 8'hF2;
  localparam logic [7:0] EN_TWO_MASK = 8'h13;
  localparam logic [7:0] ST_TWO_MASK = 8'h1B;
  localparam logic [7:0] WAKE_EN_MASK = 8'h04;
  localparam logic [1:0] IRQ_MASK_BITS = 2'h3;

  // Status bit positions
  localparam int ST1_TIMER = 7;
  localparam int ST1_MOUSE = 6;
  localparam int ST1_KEYBOARD = 5;
  localparam int ST1_HWMON = 4;
  localparam int ST1_SERIAL = 1;
  localparam int ST2_INFRARED = 4;
  localparam int ST2_ENERGY = 3;
  localparam int ST2_RING = 1;
  localparam int ST2_GPIO = 0;

  // Interrupt status bits
  localparam int IRQ_EXPIRY = 0;
  localparam int IRQ_WAKE = 1;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] TIME_RESET = 8'h00;

  // Time base
  localparam int CLK_HZ = 100_000_000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;
  localparam int MINUTE_SECONDS = 60;
  localparam logic [5:0] MINUTE_LAST = 6'(MINUTE_SECONDS - 1);

  // Standby mode encodings
  typedef enum logic [1:0] {
    PMEW_MODE_G3P = 2'h0,
    PMEW_MODE_BOTH = 2'h1,
    PMEW_MODE_RSVD = 2'h2,
    PMEW_MODE_DEEP = 2'h3
  } pmew_mode_e;

  // Wake event pulses from the source blocks, one cycle each
  typedef struct packed {
    logic mouse;
    logic keyboard;
    logic hw_monitor;
    logic serial_port;
    logic infrared;
    logic ring_indicator;
    logic gpio;
    logic energy_unit;
  } pmew_events_s;

endpackage : pmew_pkg

// file: hw/pmew_top.sv
// Wake event banks, standby watchdog and Avalon-MM register slave
// Functional notes
// [RULE1] Two-bit mode picks standby control source
// [RULE2] Follow bit makes deep power-ok track control
// [RULE3] Expired flag sets on timeout, write-1 clears
// [RULE4] Unit bit selects seconds or minutes
// [RULE5] Watchdog runs only while enable set
// [RULE6] Load eight-bit time, count down per unit
// [RULE7] At zero, clear enable, set expired flag
// [RULE8] Expiry raises wakeup only when enabled
// [RULE9] First enable bank, reset disabled
// [RULE10] First status bank, write-1 clears
// [RULE11] Second enable bank, reset disabled
// [RULE12] Second status bank, write-1 clears
// [RULE13] Software clears status to rearm source
// [RULE14] Status zero means nothing outstanding
// [RULE15] Timeout wakeup gated by wakeup enable bit
// [RULE16] Event output when enabled status pending
// [RULE17] Reserved bits read zero, ignore writes
//
// Added by the designer: register access over Avalon-MM.
module pmew_top #(
  parameter int SECOND_CYCLES = pmew_pkg::SECOND_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire pmew_pkg::pmew_events_s events_i,
  input wire logic g3_prime_scheme_n_i,
  input wire logic deep_sleep_well_n_i,
  input wire logic standby_control_one_n_i,
  input wire logic power_ok_i,
  output logic standby_control_n_o,
  output logic deep_power_ok_output_o,
  output logic wake_request_o,
  output logic pme_o,
  output logic irq_o
);

  // Pin synchronisers
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic g3p_n;
  logic deep_well_n;
  logic ctrl_one_n;
  logic pwr_ok;

  // Bus
  logic [7:0] index;
  logic req;
  logic take;
  logic wr_en;
  logic rd_en;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // Registers
  logic [1:0] mode_reg;
  logic follow_reg;
  logic expired_reg;
  logic unit_reg;
  logic enable_reg;
  logic [7:0] time_reg;
  logic [7:0] en_one_reg;
  logic [7:0] st_one_reg;
  logic [7:0] en_two_reg;
  logic [7:0] st_two_reg;
  logic wake_en_reg;
  logic [1:0] irq_st_reg;
  logic [1:0] irq_mask_reg;

  // Watchdog
  logic [31:0] prescale_reg;
  logic [5:0] minute_reg;
  logic [7:0] count_reg;
  logic enable_d_reg;
  logic sec_tick;
  logic unit_tick;
  logic expire;
  logic pme_next;
  logic pme_d_reg;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic mode_out;

  // Two flops before any logic reads a pin
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= 4'hF;
      pin_sync_reg <= 4'hF;
    end else if (ce_i) begin
      pin_meta_reg <= {g3_prime_scheme_n_i, deep_sleep_well_n_i,
                       standby_control_one_n_i, power_ok_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign g3p_n = pin_sync_reg[3];
  assign deep_well_n = pin_sync_reg[2];
  assign ctrl_one_n = pin_sync_reg[1];
  assign pwr_ok = pin_sync_reg[0];

  // Bus decode; the answer comes one cycle after the request
  assign index = avs_address_i[9:2];
  assign req = avs_read_i | avs_write_i;
  assign take = req & ~avs_waitrequest_o & ce_i;
  assign wr_en = take & avs_write_i & avs_byteenable_i[0];
  assign rd_en = take & avs_read_i;
  assign wbyte = avs_writedata_i[7:0];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
    end
  end

  always_comb begin
    rbyte = 8'h00;
    unique case (index)
      pmew_pkg::IDX_WDT_CTRL: begin
        rbyte = {mode_reg, follow_reg, expired_reg, 2'b00, unit_reg, enable_reg}; // [RULE17]
      end
      pmew_pkg::IDX_WDT_TIME: begin
        rbyte = time_reg;
      end
      pmew_pkg::IDX_EN_ONE: begin
        rbyte = en_one_reg;
      end
      pmew_pkg::IDX_ST_ONE: begin
        rbyte = st_one_reg; // [RULE14]
      end
      pmew_pkg::IDX_EN_TWO: begin
        rbyte = en_two_reg;
      end
      pmew_pkg::IDX_ST_TWO: begin
        rbyte = st_two_reg; // [RULE14]
      end
      pmew_pkg::IDX_WAKE_EN: begin
        rbyte = {5'h00, wake_en_reg, 2'h0};
      end
      pmew_pkg::IDX_IRQ_ST: begin
        rbyte = {6'h00, irq_st_reg};
      end
      pmew_pkg::IDX_IRQ_MASK: begin
        rbyte = {6'h00, irq_mask_reg};
      end
      default: begin
        rbyte = 8'h00;
      end
    endcase
  end

  // Read data held until the next answer
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i && req && avs_waitrequest_o && avs_read_i) begin
      avs_readdata_o <= {24'h00_0000, rbyte};
    end
  end

  // Mode, follow and unit fields
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= 2'h0;
      follow_reg <= 1'b0;
      unit_reg <= 1'b0;
    end else if (wr_en && index == pmew_pkg::IDX_WDT_CTRL) begin
      mode_reg <= wbyte[pmew_pkg::MODE_HI:pmew_pkg::MODE_LO];
      follow_reg <= wbyte[pmew_pkg::FOLLOW_BIT];
      unit_reg <= wbyte[pmew_pkg::UNIT_BIT]; // [RULE4]
    end
  end

  // Enable: software sets, expiry clears
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_reg <= 1'b0; // [RULE5]
    end else if (ce_i) begin
      if (expire) begin
        enable_reg <= 1'b0; // [RULE7]
      end else if (wr_en && index == pmew_pkg::IDX_WDT_CTRL) begin
        enable_reg <= wbyte[pmew_pkg::ENABLE_BIT];
      end
    end
  end

  // Expired flag; a same-cycle expiry beats the clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      expired_reg <= 1'b0;
    end else if (ce_i) begin
      if (expire) begin
        expired_reg <= 1'b1; // [RULE7]
      end else if (wr_en && index == pmew_pkg::IDX_WDT_CTRL
                   && wbyte[pmew_pkg::EXPIRED_BIT]) begin
        expired_reg <= 1'b0; // [RULE3]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_reg <= pmew_pkg::TIME_RESET;
    end else if (wr_en && index == pmew_pkg::IDX_WDT_TIME) begin
      time_reg <= wbyte;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_en_reg <= 1'b0;
    end else if (wr_en && index == pmew_pkg::IDX_WAKE_EN) begin
      wake_en_reg <= wbyte[pmew_pkg::TIMER_WAKE_BIT];
    end
  end

  // Enable banks
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_one_reg <= pmew_pkg::REG_RESET; // [RULE9]
      en_two_reg <= pmew_pkg::REG_RESET; // [RULE11]
    end else if (wr_en) begin
      if (index == pmew_pkg::IDX_EN_ONE) begin
        en_one_reg <= wbyte & pmew_pkg::EN_ONE_MASK; // [RULE9] [RULE17]
      end
      if (index == pmew_pkg::IDX_EN_TWO) begin
        en_two_reg <= wbyte & pmew_pkg::EN_TWO_MASK; // [RULE11] [RULE17]
      end
    end
  end

  // Status set terms from sources and the watchdog
  always_comb begin
    set_one = 8'h00;
    set_two = 8'h00;
    set_one[pmew_pkg::ST1_TIMER] = expire;
    set_one[pmew_pkg::ST1_MOUSE] = events_i.mouse;
    set_one[pmew_pkg::ST1_KEYBOARD] = events_i.keyboard;
    set_one[pmew_pkg::ST1_HWMON] = events_i.hw_monitor;
    set_one[pmew_pkg::ST1_SERIAL] = events_i.serial_port;
    set_two[pmew_pkg::ST2_INFRARED] = events_i.infrared;
    set_two[pmew_pkg::ST2_ENERGY] = events_i.energy_unit;
    set_two[pmew_pkg::ST2_RING] = events_i.ring_indicator;
    set_two[pmew_pkg::ST2_GPIO] = events_i.gpio;
  end

  // Status banks: write-1 clears, a new event wins over the clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_one_reg <= pmew_pkg::REG_RESET;
      st_two_reg <= pmew_pkg::REG_RESET;
    end else if (ce_i) begin
      if (wr_en && index == pmew_pkg::IDX_ST_ONE) begin
        st_one_reg <= (st_one_reg & ~wbyte | set_one) & pmew_pkg::ST_ONE_MASK; // [RULE10] [RULE13]
      end else begin
        st_one_reg <= (st_one_reg | set_one) & pmew_pkg::ST_ONE_MASK; // [RULE10]
      end
      if (wr_en && index == pmew_pkg::IDX_ST_TWO) begin
        st_two_reg <= (st_two_reg & ~wbyte | set_two) & pmew_pkg::ST_TWO_MASK; // [RULE12] [RULE13]
      end else begin
        st_two_reg <= (st_two_reg | set_two) & pmew_pkg::ST_TWO_MASK; // [RULE12]
      end
    end
  end

  // Second prescaler; free running only while the watchdog runs
  assign sec_tick = enable_reg && (prescale_reg == 32'(SECOND_CYCLES - 1));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      if (!enable_reg || sec_tick) begin
        prescale_reg <= 32'h0000_0000;
      end else begin
        prescale_reg <= prescale_reg + 32'h0000_0001; // [RULE5]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      minute_reg <= 6'h00;
    end else if (ce_i) begin
      if (!enable_reg) begin
        minute_reg <= 6'h00;
      end else if (sec_tick) begin
        if (minute_reg == pmew_pkg::MINUTE_LAST) begin
          minute_reg <= 6'h00;
        end else begin
          minute_reg <= minute_reg + 6'h01;
        end
      end
    end
  end

  assign unit_tick = unit_reg ? (sec_tick && minute_reg == pmew_pkg::MINUTE_LAST)
                              : sec_tick; // [RULE4]

  // Countdown: loaded on the enable edge, expires at zero
  assign expire = enable_reg && enable_d_reg && (count_reg == 8'h00); // [RULE7]

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_d_reg <= 1'b0;
      count_reg <= 8'h00;
    end else if (ce_i) begin
      enable_d_reg <= enable_reg;
      if (enable_reg && !enable_d_reg) begin
        count_reg <= time_reg; // [RULE6]
      end else if (enable_reg && unit_tick && count_reg != 8'h00) begin
        count_reg <= count_reg - 8'h01; // [RULE6]
      end
    end
  end

  // Wakeup to the chipset, held until the expired flag is cleared
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_request_o <= 1'b0;
    end else if (ce_i) begin
      wake_request_o <= (expire | expired_reg) & wake_en_reg; // [RULE8] [RULE15]
    end
  end

  assign pme_next = |(st_one_reg & en_one_reg) | |(st_two_reg & en_two_reg);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pme_o <= 1'b0;
      pme_d_reg <= 1'b0;
    end else if (ce_i) begin
      pme_o <= pme_next; // [RULE16]
      pme_d_reg <= pme_next;
    end
  end

  // Standby control source by mode; reserved mode keeps it released
  always_comb begin
    unique case (pmew_pkg::pmew_mode_e'(mode_reg))
      pmew_pkg::PMEW_MODE_G3P: begin
        mode_out = g3p_n; // [RULE1]
      end
      pmew_pkg::PMEW_MODE_BOTH: begin
        mode_out = g3p_n & deep_well_n; // [RULE1]
      end
      pmew_pkg::PMEW_MODE_DEEP: begin
        mode_out = deep_well_n; // [RULE1]
      end
      pmew_pkg::PMEW_MODE_RSVD: begin
        mode_out = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      standby_control_n_o <= 1'b1;
      deep_power_ok_output_o <= 1'b0;
    end else if (ce_i) begin
      standby_control_n_o <= mode_out;
      deep_power_ok_output_o <= follow_reg ? ctrl_one_n : pwr_ok; // [RULE2]
    end
  end

  // Interrupt status, cleared by a read; a new event wins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_st_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end else if (ce_i) begin
      if (rd_en && index == pmew_pkg::IDX_IRQ_ST) begin
        irq_st_reg <= {pme_next & ~pme_d_reg, expire};
      end else begin
        irq_st_reg <= irq_st_reg | {pme_next & ~pme_d_reg, expire};
      end
      if (wr_en && index == pmew_pkg::IDX_IRQ_MASK) begin
        irq_mask_reg <= wbyte[1:0] & pmew_pkg::IRQ_MASK_BITS;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      // A set mask bit hides its cause; all causes visible after reset
      irq_o <= |(irq_st_reg & ~irq_mask_reg);
    end
  end

endmodule : pmew_top

// file: verif/pmew_sva.sv
// Port-level assertions of the wake event and sleep watchdog block
module pmew_sva (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic g3_prime_scheme_n_i,
  input wire logic deep_sleep_well_n_i,
  input wire logic standby_control_one_n_i,
  input wire logic power_ok_i,
  input wire logic standby_control_n_o,
  input wire logic deep_power_ok_output_o,
  input wire logic wake_request_o,
  input wire logic pme_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] sel_pins;
  logic [1:0] ok_pins;
  logic [3:0] up_reg;
  assign sel_pins = {g3_prime_scheme_n_i, deep_sleep_well_n_i};
  assign ok_pins = {standby_control_one_n_i, power_ok_i};
  // Pin syncs preset to ones, so outputs may move just after reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_reg <= 4'h0;
    end else if (up_reg != 4'hF) begin
      up_reg <= up_reg + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_answer;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one wait cycle");
  property p_rd_zero;
    avs_readdata_o[31:8] == 24'h00_0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("upper read bits set");
  property p_pme_fall;
    $fell(pme_o) |-> $past(avs_write_i) || $past(avs_write_i, 2);
  endproperty
  a_pme_fall: assert property (p_pme_fall) else $error("pme dropped unprompted");
  property p_wake_fall;
    $fell(wake_request_o) |-> $past(avs_write_i) || $past(avs_write_i, 2);
  endproperty
  a_wake_fall: assert property (p_wake_fall) else $error("wake dropped unprompted");
  property p_irq_fall;
    $fell(irq_o) |-> $past(avs_read_i) || $past(avs_write_i)
      || $past(avs_read_i, 2) || $past(avs_write_i, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
  property p_ctl_cause;
    up_reg == 4'hF && $changed(standby_control_n_o) |-> $past(avs_write_i)
      || $past(avs_write_i, 2) || $past(avs_write_i, 3) || $past(sel_pins, 2) != $past(sel_pins, 5);
  endproperty
  a_ctl_cause: assert property (p_ctl_cause) else $error("standby control moved alone");
  property p_dpok_cause;
    up_reg == 4'hF && $changed(deep_power_ok_output_o) |-> $past(avs_write_i)
      || $past(avs_write_i, 2) || $past(avs_write_i, 3) || $past(ok_pins, 2) != $past(ok_pins, 5);
  endproperty
  a_dpok_cause: assert property (p_dpok_cause) else $error("power ok moved alone");
  property p_rst_quiet;
    disable iff (1'b0) !rst_n_i |-> avs_waitrequest_o && !pme_o && !wake_request_o
      && !irq_o && !deep_power_ok_output_o && standby_control_n_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
endmodule : pmew_sva

// file: verif/pmew_chipset_model.sv
// Chipset side: drives the standby pins and counts wake requests
module pmew_chipset_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] pin_cmd_i,
  input wire logic wake_i,
  output logic g3_n_o,
  output logic deep_n_o,
  output logic one_n_o,
  output logic pwr_ok_o,
  output logic [7:0] wake_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wake_reg;
  // Power-ok starts low so the follow path has nothing to show at start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {g3_n_o, deep_n_o, one_n_o, pwr_ok_o} <= 4'hE;
    end else begin
      {g3_n_o, deep_n_o, one_n_o, pwr_ok_o} <= pin_cmd_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_reg <= 1'b0;
      wake_cnt_o <= 8'h00;
    end else begin
      wake_reg <= wake_i;
      if (wake_i && !wake_reg) begin
        wake_cnt_o <= wake_cnt_o + 8'h01;
      end
    end
  end
endmodule : pmew_chipset_model

// file: verif/pmew_top_tb_top.sv
// Self-checking bench of the wake event and sleep watchdog block
module pmew_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 10;
  localparam logic [7:0] RST_IDX [7] = '{8'hED, 8'hEE, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'h10};
  localparam logic [7:0] ST_IDX [8] = '{8'hF3, 8'hF3, 8'hF3, 8'hF3, 8'hF1, 8'hF1, 8'hF1, 8'hF1};
  localparam logic [7:0] ST_VAL [8] = '{8'h08, 8'h01, 8'h02, 8'h10, 8'h02, 8'h10, 8'h20, 8'h40};
  logic sys_clk_i;
  logic rst_n_i;
  logic ce_i;
  logic [9:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  pmew_pkg::pmew_events_s events_i;
  logic g3_prime_scheme_n_i;
  logic deep_sleep_well_n_i;
  logic standby_control_one_n_i;
  logic power_ok_i;
  logic standby_control_n_o;
  logic deep_power_ok_output_o;
  logic wake_request_o;
  logic pme_o;
  logic irq_o;
  logic [3:0] pin_cmd;
  logic [7:0] wake_cnt;
  logic [31:0] seed;
  logic e;
  logic [31:0] exp_q[$];
  int n_mismatch;
  int tests_run;
  int cyc;
  int n;

  pmew_top #(.SECOND_CYCLES(SEC)) pmew_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .events_i(events_i),
    .g3_prime_scheme_n_i(g3_prime_scheme_n_i),
    .deep_sleep_well_n_i(deep_sleep_well_n_i),
    .standby_control_one_n_i(standby_control_one_n_i), .power_ok_i(power_ok_i),
    .standby_control_n_o(standby_control_n_o),
    .deep_power_ok_output_o(deep_power_ok_output_o),
    .wake_request_o(wake_request_o), .pme_o(pme_o), .irq_o(irq_o));
  pmew_chipset_model pmew_chipset_model_i (.clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .pin_cmd_i(pin_cmd), .wake_i(wake_request_o), .g3_n_o(g3_prime_scheme_n_i),
    .deep_n_o(deep_sleep_well_n_i), .one_n_o(standby_control_one_n_i),
    .pwr_ok_o(power_ok_i), .wake_cnt_o(wake_cnt));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // Holds the request until waitrequest is seen low, then idles one edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h00_0000, d};
    @(posedge sys_clk_i);
    while (avs_waitrequest_o) @(posedge sys_clk_i);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] d);
    exp_q.push_back({24'h00_0000, d});
    bus(1'b0, idx, 8'h00);
  endtask : rd

  task automatic wait_n(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask : wait_n

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (rst_n_i && !avs_waitrequest_o && avs_read_i) begin
      chk(avs_readdata_o, exp_q.pop_front());
    end
    if (cyc == 8000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    rst_n_i = 1'b1;
    ce_i = 1'b1;
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    avs_byteenable_i = 4'hF;
    events_i = '0;
    pin_cmd = 4'hE;
    seed = 32'hDD27_7480;
    // Reset falls after time zero so the async branches surely see it
    #1 rst_n_i = 1'b0;
    wait_n(2);
    rst_n_i <= 1'b1;
    wait_n(20);
    for (int i = 0; i < 7; i++) rd(RST_IDX[i], 8'h00);
    seed = xs(seed);
    wr(8'hF0, seed[7:0]);
    rd(8'hF0, seed[7:0] & 8'hF2);
    wr(8'hF2, seed[15:8]);
    rd(8'hF2, seed[15:8] & 8'h13);
    wr(8'hF0, 8'hF2);
    wr(8'hF2, 8'h13);
    for (int i = 0; i < 8; i++) begin
      events_i <= pmew_pkg::pmew_events_s'(8'h01 << i);
      @(posedge sys_clk_i);
      events_i <= '0;
      wait_n(2);
      chk(32'(pme_o), 32'(i != 0));
      rd(ST_IDX[i], ST_VAL[i]);
      wr(ST_IDX[i], ST_VAL[i]);
      rd(ST_IDX[i], 8'h00);
    end
    // Mask both interrupt causes, then clear by reading
    wr(8'hFB, 8'h03);
    rd(8'hFA, 8'h02);
    wait_n(2);
    chk(32'(irq_o), 32'h0);
    wr(8'hE8, 8'h04);
    wr(8'hF0, 8'h80);
    wr(8'hEE, 8'h03);
    wr(8'hED, 8'h01);
    n = 0;
    while (!wake_request_o && n < 100) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk(32'(n >= 2 * SEC && n <= 3 * SEC + 6), 32'h1);
    wait_n(2);
    chk(32'(pme_o), 32'h1);
    chk(32'(irq_o), 32'h0);
    rd(8'hED, 8'h10);
    rd(8'hF1, 8'h80);
    wr(8'hFB, 8'h00);
    wait_n(2);
    chk(32'(irq_o), 32'h1);
    rd(8'hFA, 8'h03);
    wait_n(2);
    chk(32'(irq_o), 32'h0);
    wr(8'hED, 8'h10);
    wait_n(2);
    chk(32'(wake_request_o), 32'h0);
    rd(8'hED, 8'h00);
    wr(8'hF1, 8'h80);
    // Minutes with the wakeup disabled
    wr(8'hE8, 8'h00);
    wr(8'hEE, 8'h02);
    wr(8'hED, 8'h03);
    wait_n(60 * SEC - 10);
    rd(8'hED, 8'h03);
    wait_n(60 * SEC + 60);
    rd(8'hED, 8'h12);
    chk(32'(wake_request_o), 32'h0);
    chk(32'(wake_cnt), 32'h1);
    // Write with the low byte lane off is refused
    avs_byteenable_i <= 4'hE;
    wr(8'hEE, 8'h55);
    avs_byteenable_i <= 4'hF;
    rd(8'hEE, 8'h02);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      pin_cmd <= seed[3:0];
      wr(8'hED, {i[1:0], i[2], 5'h00});
      wait_n(5);
      e = (i[1:0] == 2'h0) ? seed[3] : (i[1:0] == 2'h1) ? (seed[3] & seed[2])
        : (i[1:0] == 2'h3) ? seed[2] : 1'b1;
      chk(32'(standby_control_n_o), 32'(e));
      chk(32'(deep_power_ok_output_o), 32'(i[2] ? seed[1] : seed[0]));
    end
    stop_test();
  end
endmodule : pmew_top_tb_top

bind pmew_top pmew_sva pmew_sva_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .g3_prime_scheme_n_i(g3_prime_scheme_n_i),
  .deep_sleep_well_n_i(deep_sleep_well_n_i),
  .standby_control_one_n_i(standby_control_one_n_i), .power_ok_i(power_ok_i),
  .standby_control_n_o(standby_control_n_o),
  .deep_power_ok_output_o(deep_power_ok_output_o), .wake_request_o(wake_request_o),
  .pme_o(pme_o), .irq_o(irq_o));
